/* rtl/hsp_pkg.sv */
package hsp_pkg;
  localparam int DATA_W = 32;
  localparam int CNT_W = 16;
  localparam int DLY_W = 8;

  typedef enum logic [1:0] {
    PROTO_LEVEL,
    PROTO_TRAIL,
    PROTO_LEAD,
    PROTO_LONG
  } hsp_proto_t;

  localparam int CLK_NS = 40;
  // ready pulse base width, least time rounds up
  localparam int ACK_W_NS = 225;
  localparam logic [CNT_W-1:0] ACK_W_CYC = CNT_W'((ACK_W_NS + CLK_NS - 1) / CLK_NS);
  // request pulse width and inactive time on the peripheral side
  localparam int REQ_W_NS = 75;
  localparam logic [CNT_W-1:0] REQ_W_CYC = CNT_W'((REQ_W_NS + CLK_NS - 1) / CLK_NS);
  localparam int REQ_GAP_NS = 75;
  localparam logic [CNT_W-1:0] REQ_GAP_CYC = CNT_W'((REQ_GAP_NS + CLK_NS - 1) / CLK_NS);
  // output data hold after the request edge when edge latching is off
  localparam int DOUT_HOLD_NS = 80;
  localparam logic [CNT_W-1:0] DOUT_HOLD_CYC = CNT_W'((DOUT_HOLD_NS + CLK_NS - 1) / CLK_NS);
  // classic peripheral interface chips want at least this ready pulse
  localparam int PPI_PULSE_NS = 500;
  localparam logic [CNT_W-1:0] PPI_PULSE_CYC = CNT_W'((PPI_PULSE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [DLY_W-1:0] PPI_EXTRA_DLY = DLY_W'(PPI_PULSE_CYC - ACK_W_CYC);
endpackage

/* rtl/hsp_if.sv */
`timescale 1ns/10ps
interface hsp_if;
  import hsp_pkg::*;
  logic [DATA_W-1:0] dev_dout;
  logic dev_oe;
  logic [DATA_W-1:0] per_dout;
  logic per_oe;
  logic ack;
  logic req;
  logic [DATA_W-1:0] data;

  // shared data lines; undriven lines read as zero
  assign data = dev_oe ? dev_dout : (per_oe ? per_dout : '0);

  modport dev (
    output dev_dout,
    output dev_oe,
    output ack,
    input req,
    input data
  );

  modport per (
    output per_dout,
    output per_oe,
    output req,
    input ack,
    input data
  );
endinterface

/* rtl/hsp_dev.sv */
`timescale 1ns/10ps
module hsp_dev (
  input wire logic sys_clk,
  input wire logic rstn,
  hsp_if.dev link,
  input wire hsp_pkg::hsp_proto_t proto,
  input wire logic dir_out,
  input wire logic req_latch,
  input wire logic act_low,
  input wire logic [hsp_pkg::DLY_W-1:0] delay,
  input wire logic [hsp_pkg::DATA_W-1:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [hsp_pkg::DATA_W-1:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready
);
  import hsp_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_DLY,
    ST_ACK,
    ST_WAIT,
    ST_HOLD
  } hsp_dev_st_t;

  hsp_dev_st_t st_reg, st_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic ack_reg, ack_next;
  logic oe_reg, oe_next;
  logic [DATA_W-1:0] dout_reg, dout_next;
  logic [DATA_W-1:0] rx_data_reg, rx_data_next;
  logic rx_valid_reg, rx_valid_next;
  logic pend_reg, pend_next;
  logic seen_reg, seen_next;

  logic req_s1_reg, req_s2_reg, req_d_reg;
  logic [DATA_W-1:0] din_s1_reg, din_s2_reg;

  logic req_act, req_prev, req_rise, req_fall, evt;
  logic [CNT_W-1:0] pulse_len;
  logic [DLY_W-1:0] pre_dly;

  // data is resampled alongside the request so both line up in time
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      req_s1_reg <= 1'b0;
      req_s2_reg <= 1'b0;
      req_d_reg <= 1'b0;
      din_s1_reg <= '0;
      din_s2_reg <= '0;
    end else begin
      req_s1_reg <= link.req ^ act_low;
      req_s2_reg <= req_s1_reg;
      req_d_reg <= req_s2_reg;
      din_s1_reg <= link.data;
      din_s2_reg <= din_s1_reg;
    end
  end

  always_comb begin
    // polarity folded in before the first flop, so reset equals idle and no false edge
    req_act = req_s2_reg;
    req_prev = req_d_reg;
    req_rise = req_act & ~req_prev;
    req_fall = ~req_act & req_prev;
    // only a fresh edge counts, a request already held is ignored
    if (proto == PROTO_TRAIL) begin
      evt = req_fall;
    end else begin
      evt = req_rise;
    end
    if (proto == PROTO_LEAD) begin
      pulse_len = ACK_W_CYC;
    end else begin
      pulse_len = ACK_W_CYC + CNT_W'(delay);
    end
    if (proto == PROTO_LEVEL || proto == PROTO_LEAD) begin
      pre_dly = delay;
    end else begin
      pre_dly = '0;
    end
  end

  always_comb begin
    logic start_ack;
    logic fin;
    start_ack = 1'b0;
    fin = 1'b0;
    st_next = st_reg;
    cnt_next = cnt_reg;
    ack_next = ack_reg;
    oe_next = dir_out ? oe_reg : 1'b0;
    dout_next = dout_reg;
    rx_data_next = rx_data_reg;
    rx_valid_next = 1'b0;
    pend_next = pend_reg;
    seen_next = seen_reg;
    unique case (st_reg)
      ST_IDLE: begin
        // ready stays inactive until there is a word or room for one
        if (dir_out && tx_valid) begin
          dout_next = tx_data;
          oe_next = 1'b1;
          st_next = ST_SETUP;
        end else if (!dir_out && rx_ready) begin
          st_next = ST_SETUP;
        end
      end
      ST_SETUP: begin
        // one cycle of data settling before ready goes active
        if (pre_dly != '0) begin
          cnt_next = CNT_W'(pre_dly);
          st_next = ST_DLY;
        end else begin
          start_ack = 1'b1;
        end
      end
      ST_DLY: begin
        cnt_next = cnt_reg - 1'b1;
        if (cnt_reg <= 16'h0001) begin
          start_ack = 1'b1;
        end
      end
      ST_ACK: begin
        if (proto == PROTO_LEVEL) begin
          if (evt) begin
            ack_next = 1'b0;
            fin = 1'b1;
          end
        end else begin
          if (cnt_reg > 16'h0001) begin
            cnt_next = cnt_reg - 1'b1;
          end
          seen_next = seen_reg | evt;
          // leading pulses stretch while the request is still held
          if (cnt_reg <= 16'h0001 && (proto == PROTO_TRAIL || !req_act)) begin
            ack_next = 1'b0;
            if (seen_reg || evt) begin
              fin = 1'b1;
            end else begin
              st_next = ST_WAIT;
            end
          end
        end
      end
      ST_WAIT: begin
        if (evt) begin
          fin = 1'b1;
        end
      end
      ST_HOLD: begin
        if (req_latch) begin
          if (!req_act) begin
            st_next = ST_IDLE;
          end
        end else begin
          cnt_next = cnt_reg - 1'b1;
          if (cnt_reg <= 16'h0001) begin
            st_next = ST_IDLE;
          end
        end
      end
      default: begin
        st_next = ST_IDLE;
      end
    endcase

    if (start_ack) begin
      ack_next = 1'b1;
      cnt_next = pulse_len;
      seen_next = 1'b0;
      st_next = ST_ACK;
      if (!dir_out && pend_reg) begin
        rx_data_next = din_s2_reg;
        rx_valid_next = 1'b1;
        pend_next = 1'b0;
      end
    end

    if (fin) begin
      if (dir_out) begin
        cnt_next = DOUT_HOLD_CYC;
        st_next = ST_HOLD;
      end else begin
        st_next = ST_IDLE;
        if (req_latch) begin
          rx_data_next = din_s2_reg;
          rx_valid_next = 1'b1;
        end else begin
          pend_next = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= ST_IDLE;
      cnt_reg <= '0;
      ack_reg <= 1'b0;
      oe_reg <= 1'b0;
      dout_reg <= '0;
      rx_data_reg <= '0;
      rx_valid_reg <= 1'b0;
      pend_reg <= 1'b0;
      seen_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      ack_reg <= ack_next;
      oe_reg <= oe_next;
      dout_reg <= dout_next;
      rx_data_reg <= rx_data_next;
      rx_valid_reg <= rx_valid_next;
      pend_reg <= pend_next;
      seen_reg <= seen_next;
    end
  end

  assign link.ack = ack_reg ^ act_low;
  assign link.dev_dout = dout_reg;
  assign link.dev_oe = oe_reg;
  assign tx_ready = (st_reg == ST_IDLE) && dir_out;
  assign rx_data = rx_data_reg;
  assign rx_valid = rx_valid_reg;
endmodule // hsp_dev

/* rtl/hsp_per.sv */
`timescale 1ns/10ps
module hsp_per (
  input wire logic sys_clk,
  input wire logic rstn,
  hsp_if.per link,
  input wire hsp_pkg::hsp_proto_t proto,
  input wire logic dev_out,
  input wire logic act_low,
  input wire logic [hsp_pkg::DATA_W-1:0] send_data,
  input wire logic send_valid,
  output logic send_ready,
  output logic [hsp_pkg::DATA_W-1:0] recv_data,
  output logic recv_valid,
  input wire logic recv_ready
);
  import hsp_pkg::*;

  typedef enum logic [2:0] {
    PS_IDLE,
    PS_SET,
    PS_REQ,
    PS_WAIT,
    PS_GAP
  } hsp_per_st_t;

  hsp_per_st_t st_reg, st_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic req_reg, req_next;
  logic oe_reg, oe_next;
  logic [DATA_W-1:0] dout_reg, dout_next;
  logic [DATA_W-1:0] recv_data_reg, recv_data_next;
  logic recv_valid_reg, recv_valid_next;
  logic armed_reg, armed_next;
  logic ack_d_reg, ack_d_next;

  logic ack_act, ack_rise, ack_fall, edge_evt, go, take;

  always_comb begin
    ack_act = link.ack ^ act_low;
    ack_rise = ack_act & ~ack_d_reg;
    ack_fall = ~ack_act & ack_d_reg;
    if (proto == PROTO_TRAIL) begin
      edge_evt = ack_fall;
    end else begin
      edge_evt = ack_rise;
    end
    go = (proto == PROTO_LEVEL) ? ack_act : armed_reg;
    take = (st_reg == PS_IDLE) && go && (dev_out ? recv_ready : send_valid);
  end

  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    req_next = req_reg;
    oe_next = dev_out ? 1'b0 : oe_reg;
    dout_next = dout_reg;
    recv_data_next = recv_data_reg;
    recv_valid_next = 1'b0;
    ack_d_next = ack_act;
    // a new edge wins over the clear of the old one
    armed_next = (armed_reg & ~take) | (edge_evt & (proto != PROTO_LEVEL));
    unique case (st_reg)
      PS_IDLE: begin
        if (take) begin
          if (dev_out) begin
            recv_data_next = link.data;
            recv_valid_next = 1'b1;
            req_next = 1'b1;
            cnt_next = REQ_W_CYC;
            st_next = PS_REQ;
          end else begin
            // data changes only once the ready edge has passed
            dout_next = send_data;
            oe_next = 1'b1;
            st_next = PS_SET;
          end
        end
      end
      PS_SET: begin
        req_next = 1'b1;
        cnt_next = REQ_W_CYC;
        st_next = PS_REQ;
      end
      PS_REQ: begin
        cnt_next = cnt_reg - 1'b1;
        if (cnt_reg <= 16'h0001) begin
          if (proto == PROTO_LEVEL) begin
            st_next = PS_WAIT;
          end else begin
            req_next = 1'b0;
            cnt_next = REQ_GAP_CYC;
            st_next = PS_GAP;
          end
        end
      end
      PS_WAIT: begin
        if (!ack_act) begin
          req_next = 1'b0;
          cnt_next = REQ_GAP_CYC;
          st_next = PS_GAP;
        end
      end
      PS_GAP: begin
        cnt_next = cnt_reg - 1'b1;
        if (cnt_reg <= 16'h0001) begin
          st_next = PS_IDLE;
        end
      end
      default: begin
        st_next = PS_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= PS_IDLE;
      cnt_reg <= '0;
      req_reg <= 1'b0;
      oe_reg <= 1'b0;
      dout_reg <= '0;
      recv_data_reg <= '0;
      recv_valid_reg <= 1'b0;
      armed_reg <= 1'b0;
      ack_d_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      req_reg <= req_next;
      oe_reg <= oe_next;
      dout_reg <= dout_next;
      recv_data_reg <= recv_data_next;
      recv_valid_reg <= recv_valid_next;
      armed_reg <= armed_next;
      ack_d_reg <= ack_d_next;
    end
  end

  assign link.req = req_reg ^ act_low;
  assign link.per_dout = dout_reg;
  assign link.per_oe = oe_reg;
  assign send_ready = take && !dev_out;
  assign recv_data = recv_data_reg;
  assign recv_valid = recv_valid_reg;
endmodule // hsp_per

/* sim/hsp_asserts.sv */
`timescale 1ns/10ps
module hsp_asserts (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ack,
  input wire logic req,
  input wire logic [hsp_pkg::DATA_W-1:0] data,
  input wire logic dev_oe,
  input wire logic act_low,
  input wire hsp_pkg::hsp_proto_t proto,
  input wire logic [hsp_pkg::DLY_W-1:0] delay
);
  import hsp_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic a;
  logic r;
  logic [15:0] hi_cnt;
  logic [15:0] lo_cnt;
  // logical levels, so one set of checks covers both polarities
  assign a = ack ^ act_low;
  assign r = req ^ act_low;
  // lo_cnt saturates so a long idle spell never wraps into a false short gap
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      hi_cnt <= '0;
      lo_cnt <= '0;
    end else begin
      hi_cnt <= a ? hi_cnt + 16'h0001 : '0;
      lo_cnt <= a ? '0 : lo_cnt + {15'h0000, ~&lo_cnt};
    end
  end
  sequence s_held;
    a [*2];
  endsequence
  sequence s_drop;
    !a;
  endsequence
  a_rst_idle: assert property ($rose(rstn) |-> !a)
    else $error("ready strobe active after reset");
  a_data_first: assert property ($rose(a) && dev_oe |-> $past(dev_oe) && $stable(data))
    else $error("ready strobe before output data");
  a_level_hold: assert property (proto == PROTO_LEVEL && a && !r |=> a)
    else $error("level ready strobe dropped without request");
  a_req_sync: assert property (proto == PROTO_LEVEL && a && $rose(r) |=> s_held ##[1:3] s_drop)
    else $error("level ready strobe release timing wrong");
  a_delay_gap: assert property ((proto == PROTO_LEVEL || proto == PROTO_LEAD) && $rose(a)
      |-> lo_cnt >= 16'(delay) + 16'h0001)
    else $error("programmed delay before ready strobe missing");
  a_trail_width: assert property (proto == PROTO_TRAIL && $fell(a)
      |-> hi_cnt == ACK_W_CYC + 16'(delay))
    else $error("trailing ready pulse width wrong");
  a_edge_width: assert property ((proto == PROTO_LEAD || proto == PROTO_LONG) && $fell(a)
      |-> hi_cnt >= ACK_W_CYC + (proto == PROTO_LONG ? 16'(delay) : 16'h0000))
    else $error("edge mode ready pulse too short");
  a_trail_req: assert property (proto == PROTO_TRAIL && ($rose(r) || $fell(r)) |-> !a)
    else $error("request moved while ready pulse active");
endmodule // hsp_asserts

/* sim/tb.sv */
`timescale 1ns/10ps
module tb;
  import hsp_pkg::*;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  hsp_proto_t proto = PROTO_LEVEL;
  logic dir_out = 1'b1;
  logic req_latch = 1'b0;
  logic act_low = 1'b0;
  logic [DLY_W-1:0] delay = '0;
  logic [DATA_W-1:0] tx_data = '0;
  logic [DATA_W-1:0] send_data = '0;
  logic tx_valid = 1'b0;
  logic send_valid = 1'b0;
  logic rx_ready = 1'b1;
  logic recv_ready = 1'b1;
  logic tx_ready, rx_valid, send_ready, recv_valid;
  logic [DATA_W-1:0] rx_data, recv_data, got;
  logic [DATA_W-1:0] q[$];
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;
  hsp_if lk();
  hsp_dev hsp_dev_i (.sys_clk(sys_clk), .rstn(rstn), .link(lk.dev), .proto(proto),
    .dir_out(dir_out), .req_latch(req_latch), .act_low(act_low), .delay(delay),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready));
  hsp_per hsp_per_i (.sys_clk(sys_clk), .rstn(rstn), .link(lk.per), .proto(proto),
    .dev_out(dir_out), .act_low(act_low), .send_data(send_data), .send_valid(send_valid),
    .send_ready(send_ready), .recv_data(recv_data), .recv_valid(recv_valid),
    .recv_ready(recv_ready));
  hsp_asserts hsp_asserts_i (.sys_clk(sys_clk), .rstn(rstn), .ack(lk.ack), .req(lk.req),
    .data(lk.data), .dev_oe(lk.dev_oe), .act_low(act_low), .proto(proto), .delay(delay));
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // reset between tests: flipping polarity while live would look like a strobe edge
  task automatic run(input hsp_proto_t p, input logic d, input logic al, input logic lat,
      input logic [DLY_W-1:0] dl);
    logic [DATA_W-1:0] w;
    int k;
    rstn <= 1'b0;
    proto <= p;
    dir_out <= d;
    act_low <= al;
    req_latch <= lat;
    delay <= dl;
    repeat (2) @(posedge sys_clk);
    chk(DATA_W'(lk.ack), DATA_W'(al));
    rstn <= 1'b1;
    for (k = 0; k < 6; k++) begin
      w = $urandom;
      tx_data <= w;
      send_data <= w;
      tx_valid <= d;
      send_valid <= !d;
      do @(posedge sys_clk); while (!(d ? tx_ready : send_ready));
      q.push_back(w);
    end
    tx_valid <= 1'b0;
    send_valid <= 1'b0;
    for (k = 0; k < 600 && q.size() != 0; k++) @(posedge sys_clk);
    chk(DATA_W'(q.size()), '0);
    $display("test proto %0d dir_out %0b delay %0d done", p, d, dl);
  endtask
  // both receiving sides stall at random to delay the next transfer
  always @(posedge sys_clk) begin
    rx_ready <= ($urandom % 4) != 0;
    recv_ready <= ($urandom % 4) != 0;
    cyc <= cyc + 1;
    // an unknown valid still forces a compare
    if ((dir_out ? recv_valid : rx_valid) !== 1'b0) begin
      got = dir_out ? recv_data : rx_data;
      chk(got, q.size() != 0 ? q.pop_front() : ~got);
    end
    if (cyc > 20000) begin
      errors++;
      test_done();
    end
  end
  initial begin
    void'($urandom(27));
    run(PROTO_LEVEL, 1'b1, 1'b0, 1'b0, 8'h00);
    run(PROTO_LEVEL, 1'b1, 1'b1, 1'b1, 8'h03);
    run(PROTO_LEVEL, 1'b0, 1'b1, 1'b1, 8'h00);
    run(PROTO_LEVEL, 1'b0, 1'b0, 1'b0, 8'h02);
    run(PROTO_TRAIL, 1'b0, 1'b0, 1'b1, 8'h00);
    run(PROTO_TRAIL, 1'b0, 1'b1, 1'b1, DLY_W'($urandom % 4));
    run(PROTO_TRAIL, 1'b1, 1'b0, 1'b0, 8'h00);
    run(PROTO_LEAD, 1'b0, 1'b0, 1'b1, 8'h02);
    run(PROTO_LEAD, 1'b1, 1'b1, 1'b0, 8'h00);
    run(PROTO_LONG, 1'b0, 1'b1, 1'b1, PPI_EXTRA_DLY);
    run(PROTO_LONG, 1'b1, 1'b0, 1'b0, 8'h01);
    test_done();
  end
endmodule // tb
